// >>> design/prom_consts.svh
// Constants for the configuration memory readout.
// Assumes a 50 MHz core clock and a 16-bit internal memory word.
`ifndef PROM_CONSTS_SVH
`define PROM_CONSTS_SVH

// ------------------------------------------------------------
// Memory geometry
// ------------------------------------------------------------
`define WORD_W 16
`define ADDR_W 21
`define OFS_W 19
`define BLK_W 2
`define NUM_BLOCKS 4
`define ERASED_WORD 16'hffff
`define OFS_LAST 19'h7ffff

// ------------------------------------------------------------
// Stream path
// ------------------------------------------------------------
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define BIT_CNT_W 4
`define BIT_LAST 4'hf
`define REV_W 2
`define SYNC_W 7

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_MHZ 50
`define RELOAD_PULSE_NS 500
`define RELOAD_PULSE_CYC ((`RELOAD_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define RELOAD_CNT_W 5

`endif

// >>> design/prom_pkg.sv
// Types shared by the configuration memory readout.
// Assumes prom_consts.svh is compiled alongside.
package prom_pkg;

  typedef enum logic [1:0] {
    ST_POWERUP = 2'b00,
    ST_STREAM = 2'b01,
    ST_END = 2'b10
  } load_state_t;

endpackage

// >>> design/config_prom_readout.sv
// Serial readout of a configuration memory with four selectable revisions.
// Assumes the configuration pins arrive asynchronously and the load clock
// is far slower than core_clk, so every one of its edges is seen.
`timescale 1ns/1ns
`include "prom_consts.svh"

// ------------------------------------------------------------
// Word FIFO between memory reader and serializer
// ------------------------------------------------------------
module word_fifo #(
  parameter int WIDTH = `WORD_W,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int AW = `FIFO_AW
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wr_r;
  logic [AW:0] wr_nxt;
  logic [AW:0] rd_r;
  logic [AW:0] rd_nxt;
  logic push;
  logic pop;

  assign in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_r != rd_r;
  assign out_data = mem[rd_r[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    if (flush) begin
      wr_nxt = '0;
      rd_nxt = '0;
    end else begin
      if (push) begin
        wr_nxt = wr_r + (AW+1)'(1);
      end
      if (pop) begin
        rd_nxt = rd_r + (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push && !flush) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end
endmodule

// ------------------------------------------------------------
// Readout top
// ------------------------------------------------------------
module config_prom_readout
  import prom_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic config_load_clock,
  input wire logic chip_select_n,
  input wire logic out_enable_reset_n,
  input wire logic reload_request_pin_in,
  output logic reload_request_pin_out,
  output logic reload_request_pin_oe_n,
  input wire logic [`REV_W-1:0] revision_choice_pins,
  input wire logic pin_choice_enable,
  input wire logic [`REV_W-1:0] rev_ctrl_bits,
  input wire logic [2*`NUM_BLOCKS-1:0] rev_first_blocks,
  input wire logic [2*`NUM_BLOCKS-1:0] rev_last_blocks,
  input wire logic continue_to_next,
  input wire logic sourced_clock_enable,
  input wire logic jtag_reload,
  input wire logic prog_we,
  input wire logic [`ADDR_W-1:0] prog_addr,
  input wire logic [`WORD_W-1:0] prog_data,
  output logic config_data_out,
  output logic config_data_en,
  output logic sourced_clock_out,
  output logic next_stage_enable_n,
  output logic [`REV_W-1:0] active_revision
);

  function automatic logic [`BLK_W-1:0] block_of(input logic [`ADDR_W-1:0] a);
    block_of = a[`ADDR_W-1:`OFS_W];
  endfunction

  function automatic logic [`BLK_W-1:0] pick_block(input logic [2*`NUM_BLOCKS-1:0] map,
                                                   input logic [`REV_W-1:0] rev);
    pick_block = map[2*rev +: 2];
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [`SYNC_W-1:0] pins_raw;
  logic [`SYNC_W-1:0] meta_r;
  logic [`SYNC_W-1:0] sync_r;
  logic [`SYNC_W-1:0] prev_r;

  assign pins_raw = {pin_choice_enable, revision_choice_pins, reload_request_pin_in,
                     out_enable_reset_n, chip_select_n, config_load_clock};

  genvar gi;
  generate
    for (gi = 0; gi < `SYNC_W; gi++) begin : g_sync
      // The chain keeps running through reset, so the power-up sample sees the real pins
      // and no false edge appears when reset is released.
      always_ff @(posedge core_clk) begin
        meta_r[gi] <= pins_raw[gi];
        sync_r[gi] <= meta_r[gi];
        prev_r[gi] <= sync_r[gi];
      end
    end
  endgenerate

  logic clk_rise;
  logic cs_low;
  logic oe_high;
  logic cs_rise;
  logic oe_fall;
  logic reload_rise;
  logic [`REV_W-1:0] pins_rev;
  logic ext_sel_high;

  assign clk_rise = sync_r[0] && !prev_r[0];
  assign cs_low = !sync_r[1];
  assign cs_rise = sync_r[1] && !prev_r[1];
  assign oe_high = sync_r[2];
  assign oe_fall = !sync_r[2] && prev_r[2] && cs_low;
  assign reload_rise = sync_r[3] && !prev_r[3] && cs_low;
  assign pins_rev = sync_r[5:4];
  assign ext_sel_high = sync_r[6];

  // ------------------------------------------------------------
  // Programming port and fill marks
  // ------------------------------------------------------------
  // Words past a block's fill mark were never written and read as erased,
  // so a short revision is padded to the block end without a full erase.
  logic [`WORD_W-1:0] store [0:(1<<`ADDR_W)-1];
  logic [`OFS_W:0] fill_r [0:`NUM_BLOCKS-1];

  always_ff @(posedge core_clk) begin
    if (prog_we) begin
      store[prog_addr] <= prog_data;
    end
  end

  generate
    for (gi = 0; gi < `NUM_BLOCKS; gi++) begin : g_fill
      logic [`OFS_W:0] fill_nxt;
      always_comb begin
        fill_nxt = fill_r[gi];
        if (prog_we && block_of(prog_addr) == `BLK_W'(gi) &&
            {1'b0, prog_addr[`OFS_W-1:0]} >= fill_r[gi]) begin
          fill_nxt = {1'b0, prog_addr[`OFS_W-1:0]} + (`OFS_W+1)'(1);
        end
      end
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          fill_r[gi] <= '0;
        end else begin
          fill_r[gi] <= fill_nxt;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Revision choice and address counter
  // ------------------------------------------------------------
  load_state_t state_r;
  load_state_t state_nxt;
  logic [`REV_W-1:0] rev_r;
  logic [`REV_W-1:0] rev_nxt;
  logic [`ADDR_W-1:0] addr_r;
  logic [`ADDR_W-1:0] addr_nxt;
  logic rd_pend_r;
  logic rd_pend_nxt;
  logic [`WORD_W-1:0] rd_word_r;
  logic [`WORD_W-1:0] rd_word_nxt;
  logic chain_r;
  logic chain_nxt;
  logic [`RELOAD_CNT_W-1:0] rl_cnt_r;
  logic [`RELOAD_CNT_W-1:0] rl_cnt_nxt;
  logic [`REV_W-1:0] chosen;
  logic resample;
  logic restart;
  logic last_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [`WORD_W-1:0] fifo_out_data;

  assign chosen = ext_sel_high ? rev_ctrl_bits : pins_rev;
  assign resample = cs_rise || oe_fall || reload_rise || jtag_reload;
  assign restart = resample || !oe_high;
  assign last_word = block_of(addr_r) == pick_block(rev_last_blocks, rev_r) &&
                     addr_r[`OFS_W-1:0] == `OFS_LAST;

  always_comb begin
    state_nxt = state_r;
    rev_nxt = rev_r;
    addr_nxt = addr_r;
    rd_pend_nxt = 1'b0;
    rd_word_nxt = rd_word_r;
    chain_nxt = chain_r;
    rl_cnt_nxt = rl_cnt_r;
    if (jtag_reload) begin
      rl_cnt_nxt = `RELOAD_CNT_W'(`RELOAD_PULSE_CYC);
    end else if (rl_cnt_r != '0) begin
      rl_cnt_nxt = rl_cnt_r - `RELOAD_CNT_W'(1);
    end
    case (state_r)
      ST_POWERUP: begin
        rev_nxt = chosen;
        addr_nxt = {pick_block(rev_first_blocks, chosen), `OFS_W'(0)};
        state_nxt = ST_STREAM;
      end
      ST_STREAM, ST_END: begin
        if (restart) begin
          if (resample) begin
            rev_nxt = chosen;
          end
          addr_nxt = {pick_block(rev_first_blocks, resample ? chosen : rev_r), `OFS_W'(0)};
          chain_nxt = 1'b0;
          state_nxt = ST_STREAM;
        end else if (state_r == ST_STREAM && cs_low && fifo_in_ready && !rd_pend_r) begin
          // One read per two cycles keeps the in-flight word inside the FIFO's room.
          rd_pend_nxt = 1'b1;
          rd_word_nxt = ({1'b0, addr_r[`OFS_W-1:0]} < fill_r[block_of(addr_r)])
                        ? store[addr_r] : `ERASED_WORD;
          if (last_word) begin
            state_nxt = ST_END;
          end else begin
            addr_nxt = addr_r + `ADDR_W'(1);
          end
        end else if (state_r == ST_END && !fifo_out_valid && !rd_pend_r && continue_to_next) begin
          chain_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_POWERUP;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= ST_POWERUP;
      rev_r <= '0;
      addr_r <= '0;
      rd_pend_r <= 1'b0;
      rd_word_r <= `ERASED_WORD;
      chain_r <= 1'b0;
      rl_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      rev_r <= rev_nxt;
      addr_r <= addr_nxt;
      rd_pend_r <= rd_pend_nxt;
      rd_word_r <= rd_word_nxt;
      chain_r <= chain_nxt;
      rl_cnt_r <= rl_cnt_nxt;
    end
  end

  word_fifo #(
    .WIDTH(`WORD_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .flush(restart),
    .in_valid(rd_pend_r && !restart),
    .in_ready(fifo_in_ready),
    .in_data(rd_word_r),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // ------------------------------------------------------------
  // Serializer
  // ------------------------------------------------------------
  logic [`WORD_W-1:0] shift_r;
  logic [`WORD_W-1:0] shift_nxt;
  logic [`BIT_CNT_W-1:0] bit_r;
  logic [`BIT_CNT_W-1:0] bit_nxt;
  logic loaded_r;
  logic loaded_nxt;
  logic step;

  // A bit is consumed only on a load clock rise that the host may sample.
  assign step = clk_rise && cs_low && oe_high && loaded_r;
  assign fifo_pop = !restart && (!loaded_r || (step && bit_r == `BIT_LAST)) && fifo_out_valid;

  always_comb begin
    shift_nxt = shift_r;
    bit_nxt = bit_r;
    loaded_nxt = loaded_r;
    if (restart) begin
      loaded_nxt = 1'b0;
      bit_nxt = '0;
    end else if (fifo_pop) begin
      shift_nxt = fifo_out_data;
      bit_nxt = '0;
      loaded_nxt = 1'b1;
    end else if (step) begin
      shift_nxt = {shift_r[`WORD_W-2:0], 1'b1};
      bit_nxt = bit_r + `BIT_CNT_W'(1);
      loaded_nxt = bit_r != `BIT_LAST;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shift_r <= `ERASED_WORD;
      bit_r <= '0;
      loaded_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      bit_r <= bit_nxt;
      loaded_r <= loaded_nxt;
    end
  end

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  logic data_nxt;
  logic data_en_nxt;
  logic sclk_nxt;

  always_comb begin
    data_nxt = loaded_nxt ? shift_nxt[`WORD_W-1] : 1'b1;
    data_en_nxt = cs_low && oe_high && !chain_r;
    // The sourced clock follows the load clock only while this memory streams.
    sclk_nxt = sourced_clock_enable && data_en_nxt && state_r != ST_POWERUP
               ? sync_r[0] : 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      config_data_out <= 1'b1;
      config_data_en <= 1'b0;
      sourced_clock_out <= 1'b1;
      next_stage_enable_n <= 1'b1;
      active_revision <= '0;
      reload_request_pin_out <= 1'b0;
      reload_request_pin_oe_n <= 1'b1;
    end else begin
      config_data_out <= data_nxt;
      config_data_en <= data_en_nxt;
      sourced_clock_out <= sclk_nxt;
      next_stage_enable_n <= !(chain_nxt && cs_low);
      active_revision <= rev_nxt;
      reload_request_pin_out <= 1'b0;
      reload_request_pin_oe_n <= rl_cnt_nxt == '0;
    end
  end

endmodule

// >>> dv/prom_readout_sva.sv
// Port checks for the configuration memory readout.
// Assumes one core clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
`include "prom_consts.svh"
module prom_readout_sva (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic out_enable_reset_n,
  input wire logic reload_request_pin_in,
  input wire logic reload_request_pin_out,
  input wire logic reload_request_pin_oe_n,
  input wire logic [`REV_W-1:0] revision_choice_pins,
  input wire logic pin_choice_enable,
  input wire logic [`REV_W-1:0] rev_ctrl_bits,
  input wire logic continue_to_next,
  input wire logic sourced_clock_enable,
  input wire logic jtag_reload,
  input wire logic config_data_out,
  input wire logic config_data_en,
  input wire logic sourced_clock_out,
  input wire logic next_stage_enable_n,
  input wire logic [`REV_W-1:0] active_revision
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // The pulse is counted in logic because a 25-fold repetition unrolls badly.
  logic [7:0] low_cnt_r;
  logic [7:0] low_cnt_nxt;
  always_comb begin
    low_cnt_nxt = (sys_rst || reload_request_pin_oe_n) ? 8'h00 : low_cnt_r + 8'h01;
  end
  always_ff @(posedge core_clk) begin
    low_cnt_r <= low_cnt_nxt;
  end
  sequence pins_settled_s;
    (!pin_choice_enable && $stable(pin_choice_enable) && $stable(revision_choice_pins))[*4];
  endsequence
  sequence bits_settled_s;
    (pin_choice_enable && $stable(pin_choice_enable))[*4];
  endsequence
  sequence quiet_s;
    ($stable(chip_select_n) && $stable(out_enable_reset_n) && $stable(reload_request_pin_in) && !jtag_reload)[*6];
  endsequence
  rev_from_pins_a: assert property (pins_settled_s ##0 jtag_reload ##1 $stable(revision_choice_pins)[*2]
    |-> ##[0:1] active_revision == revision_choice_pins) else $error("revision not taken from pins");
  rev_from_bits_a: assert property (bits_settled_s ##0 jtag_reload |-> ##[1:3] active_revision == rev_ctrl_bits)
    else $error("revision not taken from control bits");
  rev_hold_a: assert property (quiet_s |=> $stable(active_revision))
    else $error("revision changed without a sampling event");
  open_drain_a: assert property (!reload_request_pin_out) else $error("reload pin driven high");
  pulse_start_a: assert property (jtag_reload |-> ##[1:2] !reload_request_pin_oe_n)
    else $error("reload pulse did not start");
  pulse_len_a: assert property ($rose(reload_request_pin_oe_n) |-> low_cnt_r == `RELOAD_PULSE_CYC)
    else $error("reload pulse length wrong");
  reset_hold_a: assert property ((!out_enable_reset_n)[*4] |-> config_data_out && sourced_clock_out)
    else $error("output active while held in reset");
  data_active_a: assert property ((!chip_select_n && out_enable_reset_n && next_stage_enable_n)[*5] |-> config_data_en)
    else $error("data driver off while selected");
  chain_gate_a: assert property ($fell(next_stage_enable_n) |-> continue_to_next)
    else $error("chain enable without continuation");
  sclk_off_a: assert property ((!sourced_clock_enable)[*2] |-> sourced_clock_out)
    else $error("sourced clock runs while disabled");
endmodule

// >>> dv/config_host_model.sv
// Behavioural configuration host: clocks the readout and collects its bits.
// Assumes a 20 ns core clock; every pin changes on its falling edge except reload_request_pin_in, which also follows reload_request_pin_oe_n.
`timescale 1ns/1ns
module config_host_model (
  input wire logic core_clk,
  input wire logic config_data_out,
  input wire logic reload_request_pin_oe_n,
  output logic config_load_clock,
  output logic chip_select_n,
  output logic out_enable_reset_n,
  output logic reload_request_pin_in
);
  logic prog_req_n;
  // Pulled-up wire: low while either party pulls it.
  assign reload_request_pin_in = prog_req_n & reload_request_pin_oe_n;
  initial begin
    config_load_clock = 1'b0;
    chip_select_n = 1'b0;
    out_enable_reset_n = 1'b1;
    prog_req_n = 1'b1;
  end
  task automatic restart();
    @(negedge core_clk);
    out_enable_reset_n = 1'b0;
    repeat (4) @(negedge core_clk);
    out_enable_reset_n = 1'b1;
    repeat (40) @(negedge core_clk);
  endtask
  // The clock rests low between words, so nothing advances outside a frame.
  task automatic shift_word(output logic [15:0] w);
    w = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      repeat (4) @(negedge core_clk);
      w = {w[14:0], config_data_out};
      config_load_clock = 1'b1;
      repeat (4) @(negedge core_clk);
      config_load_clock = 1'b0;
    end
  endtask
  task automatic pulse_select();
    @(negedge core_clk);
    chip_select_n = 1'b1;
    repeat (6) @(negedge core_clk);
    chip_select_n = 1'b0;
    repeat (10) @(negedge core_clk);
  endtask
  task automatic pulse_program();
    @(negedge core_clk);
    prog_req_n = 1'b0;
    repeat (6) @(negedge core_clk);
    prog_req_n = 1'b1;
    repeat (10) @(negedge core_clk);
  endtask
endmodule

// >>> dv/config_prom_revision_readout_bench.sv
// Self-checking bench for the configuration memory readout.
// Assumes the host model and the port checker compiled before it.
`timescale 1ns/1ns
`include "prom_consts.svh"
module config_prom_revision_readout_bench;
  logic core_clk, sys_rst, config_load_clock, chip_select_n, out_enable_reset_n, reload_request_pin_in;
  logic reload_request_pin_out, reload_request_pin_oe_n, pin_choice_enable, continue_to_next;
  logic sourced_clock_enable, jtag_reload, prog_we, config_data_out, config_data_en;
  logic sourced_clock_out, next_stage_enable_n;
  logic [`REV_W-1:0] revision_choice_pins, rev_ctrl_bits, active_revision;
  logic [2*`NUM_BLOCKS-1:0] rev_first_blocks, rev_last_blocks;
  logic [`ADDR_W-1:0] prog_addr;
  logic [`WORD_W-1:0] prog_data, w;
  int fail_count, cmp_count, n;
  config_prom_readout i_dut (.core_clk, .sys_rst, .config_load_clock, .chip_select_n, .out_enable_reset_n,
    .reload_request_pin_in, .reload_request_pin_out, .reload_request_pin_oe_n, .revision_choice_pins,
    .pin_choice_enable, .rev_ctrl_bits, .rev_first_blocks, .rev_last_blocks, .continue_to_next,
    .sourced_clock_enable, .jtag_reload, .prog_we, .prog_addr, .prog_data, .config_data_out, .config_data_en,
    .sourced_clock_out, .next_stage_enable_n, .active_revision);
  config_host_model i_host (.core_clk, .config_data_out, .reload_request_pin_oe_n, .config_load_clock,
    .chip_select_n, .out_enable_reset_n, .reload_request_pin_in);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic write_word(input logic [`ADDR_W-1:0] a, input logic [15:0] d);
    @(negedge core_clk);
    prog_we = 1'b1;
    prog_addr = a;
    prog_data = d;
    @(negedge core_clk);
    prog_we = 1'b0;
  endtask
  task automatic t_stream();
    sourced_clock_enable = 1'b1;
    write_word(21'h100000, 16'ha5c3);
    write_word(21'h080000, 16'h3c5a);
    i_host.restart();
    i_host.shift_word(w);
    check("revision 2 first word", 16'ha5c3, w);
    i_host.shift_word(w);
    check("padding word", 16'hffff, w);
    i_host.restart();
    i_host.shift_word(w);
    check("word after restart", 16'ha5c3, w);
  endtask
  task automatic t_ctrl();
    pin_choice_enable = 1'b1;
    rev_ctrl_bits = 2'h1;
    revision_choice_pins = 2'h3;
    i_host.pulse_select();
    check("revision from bits", 16'h0001, 16'(active_revision));
    rev_ctrl_bits = 2'h2;
    jtag_reload = 1'b1;
    @(negedge core_clk);
    jtag_reload = 1'b0;
    repeat (2) @(negedge core_clk);
    check("revision after jtag bits", 16'h0002, 16'(active_revision));
    rev_ctrl_bits = 2'h1;
    i_host.restart();
    i_host.shift_word(w);
    check("revision 1 first word", 16'h3c5a, w);
  endtask
  task automatic t_jtag();
    sourced_clock_enable = 1'b0;
    pin_choice_enable = 1'b0;
    repeat (4) @(negedge core_clk);
    jtag_reload = 1'b1;
    @(negedge core_clk);
    jtag_reload = 1'b0;
    n = 0;
    for (int i = 0; i < 40; i++) begin
      if (reload_request_pin_oe_n === 1'b0) n++;
      @(negedge core_clk);
    end
    check("reload pulse cycles", 16'(`RELOAD_PULSE_CYC), 16'(n));
    check("revision after jtag", 16'h0003, 16'(active_revision));
    revision_choice_pins = 2'h0;
    i_host.pulse_program();
    check("revision after reload pin", 16'h0000, 16'(active_revision));
    i_host.restart();
    i_host.shift_word(w);
    check("unwritten block word", 16'hffff, w);
  endtask
  initial begin
    fail_count = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    revision_choice_pins = 2'h2;
    pin_choice_enable = 1'b0;
    rev_ctrl_bits = 2'h0;
    rev_first_blocks = 8'he4;
    rev_last_blocks = 8'he4;
    continue_to_next = 1'b0;
    sourced_clock_enable = 1'b0;
    jtag_reload = 1'b0;
    prog_we = 1'b0;
    prog_addr = '0;
    prog_data = '0;
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge core_clk);
    check("power-up revision", 16'h0002, 16'(active_revision));
    check("data enable", 16'h0001, 16'(config_data_en));
    t_stream();
    t_ctrl();
    t_jtag();
    print_verdict();
  end
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
endmodule
bind config_prom_readout prom_readout_sva i_sva (.core_clk, .sys_rst, .chip_select_n, .out_enable_reset_n,
  .reload_request_pin_in, .reload_request_pin_out, .reload_request_pin_oe_n, .revision_choice_pins,
  .pin_choice_enable, .rev_ctrl_bits, .continue_to_next, .sourced_clock_enable, .jtag_reload,
  .config_data_out, .config_data_en, .sourced_clock_out, .next_stage_enable_n, .active_revision);
